// *** logic/in_ep_ctl_pkg.sv ***
package in_ep_ctl_pkg;

    // ------------------------------------------------------------
    // Register map (byte address = 4 x register index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTL_LOW    = 8'h11;  // Control low register index
    localparam logic [7:0] IDX_INDEX      = 8'h0E;  // Endpoint select index
    localparam logic [7:0] IDX_CTL_HIGH   = 8'h12;  // Mode bits (ISO, double buffer)
    localparam logic [7:0] IDX_IRQ_STAT   = 8'h20;  // Sticky event status
    localparam logic [7:0] IDX_IRQ_CLR    = 8'h21;  // Write-one-to-clear
    localparam logic [7:0] IDX_IRQ_EN     = 8'h22;  // Interrupt enable
    localparam logic [7:0] IDX_EP_STATUS  = 8'h23;  // Packet count readback

    // ------------------------------------------------------------
    // Control low field positions
    // ------------------------------------------------------------
    localparam int B_PKT_RDY   = 0;
    localparam int B_FIFO_NE   = 1;
    localparam int B_UNDERRUN  = 2;
    localparam int B_FLUSH     = 3;
    localparam int B_SEND_STL  = 4;
    localparam int B_STL_SENT  = 5;
    localparam int B_CLR_TOG   = 6;

    // Control high field positions
    localparam int B_ISO       = 6;
    localparam int B_DBL_BUF   = 7;

    // Interrupt status bit positions, per endpoint base
    localparam int B_EV_TX     = 0;
    localparam int B_EV_FLUSH  = 1;
    localparam int B_EV_STALL  = 2;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int          NUM_EP     = 2;
    localparam logic [7:0]  CTL_RST    = 8'h00;
    localparam logic [1:0]  CNT_ONE    = 2'h1;
    localparam logic [1:0]  CNT_ZERO   = 2'h0;
    localparam logic [1:0]  EP_FIRST   = 2'h1;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // Answer given to one IN token
    typedef enum logic [1:0] {
        ANS_NONE  = 2'b00,
        ANS_DATA  = 2'b01,
        ANS_NAK   = 2'b10,
        ANS_STALL = 2'b11
    } answer_t;

    // Token from the link: valid flag and endpoint number
    typedef struct packed {
        logic       valid;
        logic [1:0] ep;
    } token_t;

    // Per-endpoint state
    typedef struct packed {
        logic [1:0] pkts;      // Packets queued in the FIFO
        logic       rdy;       // Packet ready bit
        logic       toggle;    // Data toggle
        logic       stl_req;   // Send stall request
        logic       stl_sent;  // Stall sent flag
        logic       underrun;  // Underrun flag
        logic       flush;     // Flush in progress
        logic       iso;       // Isochronous mode
        logic       dbl;       // Double buffering
    } ep_t;

endpackage

// *** logic/usb_in_endpoint_control_low.sv ***
// What this block does
// - Clear-toggle write forces data toggle to zero
// - Clear-toggle bit always reads back zero
// - Stall handshake sent sets stall-sent flag
// - Send-stall held answers every IN with STALL
// - Send-stall ignored in isochronous mode
// - Flush write discards exactly one queued packet
// - Flush decrements packet count, clears packet-ready bit
// - Flush bit self-clears when flush completes
// - Iso IN without packet: zero-length, set underrun
// - FIFO-not-empty shows packets are queued
// - Packet-ready cleared on send or open slot
// - Index register selects visible endpoint
//
// Register access over Avalon-MM is this design's own decision.
module usb_in_endpoint_control_low (
    input  wire logic                     clk_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     clk_en_i,
    // Avalon-MM slave
    input  wire logic [9:0]               avs_address_i,
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [31:0]              avs_writedata_i,
    input  wire logic [3:0]               avs_byteenable_i,
    output logic      [31:0]              avs_readdata_o,
    output logic                          avs_waitrequest_o,
    // Link side: IN token and its answer
    input  wire logic                     token_valid_i,
    input  wire logic [1:0]               token_ep_i,
    input  wire logic                     host_ack_i,
    output logic      [1:0]               answer_o,
    output logic                          answer_zero_len_o,
    output logic                          answer_toggle_o,
    // Local FIFO load strobe (one packet written into an endpoint FIFO)
    input  wire logic                     load_valid_i,
    input  wire logic [1:0]               load_ep_i,
    output logic                          irq_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    in_ep_ctl_pkg::ep_t            ep_r   [in_ep_ctl_pkg::NUM_EP];  // Endpoint state
    in_ep_ctl_pkg::ep_t            ep_nxt [in_ep_ctl_pkg::NUM_EP];
    logic [1:0]                    sel_r;        // Selected endpoint
    logic [1:0]                    sel_nxt;
    logic [5:0]                    stat_r;       // Sticky interrupt status
    logic [5:0]                    stat_nxt;
    logic [5:0]                    en_r;         // Interrupt enables
    logic [5:0]                    en_nxt;
    logic                          ack_r;        // Bus answer pending
    logic                          ack_nxt;
    logic [31:0]                   rdata_r;      // Registered read data
    logic [31:0]                   rdata_nxt;
    logic [1:0]                    ans_r;        // Registered link answer
    logic [1:0]                    ans_nxt;
    logic                          zl_r;
    logic                          zl_nxt;
    logic                          tog_r;
    logic                          tog_nxt;

    // Decoded bus access
    logic [7:0]                    idx;
    logic                          wr;
    logic                          rd;
    logic [7:0]                    wb;
    logic                          sel_ok;
    logic [0:0]                    si;

    assign idx    = avs_address_i[9:2];
    // Writes land at the completing edge, where waitrequest is seen low
    assign wr     = avs_write_i && ack_r && avs_byteenable_i[0];
    assign rd     = avs_read_i && !ack_r;
    assign wb     = avs_writedata_i[7:0];
    // Endpoint 1 or 2 selected
    assign sel_ok = (sel_r == in_ep_ctl_pkg::EP_FIRST) || (sel_r == 2'h2);
    assign si     = sel_r[1:1];

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
    assign avs_readdata_o    = rdata_r;
    assign answer_o          = ans_r;
    assign answer_zero_len_o = zl_r;
    assign answer_toggle_o   = tog_r;
    assign irq_o             = |(stat_r & en_r);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        in_ep_ctl_pkg::ep_t e;
        logic [0:0]         ti;
        e         = '0;
        ti        = token_ep_i[1:1];
        sel_nxt   = sel_r;
        stat_nxt  = stat_r;
        en_nxt    = en_r;
        ack_nxt   = 1'b0;
        rdata_nxt = rdata_r;
        ans_nxt   = in_ep_ctl_pkg::ANS_NONE;
        zl_nxt    = 1'b0;
        tog_nxt   = 1'b0;
        for (int i = 0; i < in_ep_ctl_pkg::NUM_EP; i++) begin
            ep_nxt[i]       = ep_r[i];
            // Flush completes one cycle after it was requested
            if (ep_r[i].flush) begin
                ep_nxt[i].flush = 1'b0;
            end
        end

        // Bus access: answer one cycle after the request
        if ((avs_read_i || avs_write_i) && !ack_r) begin
            ack_nxt = 1'b1;
        end

        // Software clears of interrupt status (set wins below)
        if (wr && idx == in_ep_ctl_pkg::IDX_IRQ_CLR) begin
            stat_nxt = stat_r & ~wb[5:0];
        end

        // Link: one IN token
        if (token_valid_i && (token_ep_i == 2'h1 || token_ep_i == 2'h2)) begin
            e = ep_r[ti];
            if (e.stl_req && !e.iso) begin
                ans_nxt              = in_ep_ctl_pkg::ANS_STALL;
                ep_nxt[ti].stl_sent  = 1'b1;
                stat_nxt[3*ti + in_ep_ctl_pkg::B_EV_STALL] = 1'b1;
            end else if (e.pkts != in_ep_ctl_pkg::CNT_ZERO) begin
                ans_nxt             = in_ep_ctl_pkg::ANS_DATA;
                tog_nxt             = e.toggle;
                ep_nxt[ti].pkts     = e.pkts - in_ep_ctl_pkg::CNT_ONE;
                ep_nxt[ti].rdy      = 1'b0;
                stat_nxt[3*ti + in_ep_ctl_pkg::B_EV_TX] = 1'b1;
                if (e.iso || host_ack_i) begin
                    ep_nxt[ti].toggle = ~e.toggle;
                end
            end else if (e.iso) begin
                ans_nxt              = in_ep_ctl_pkg::ANS_DATA;
                zl_nxt               = 1'b1;
                tog_nxt              = e.toggle;
                ep_nxt[ti].underrun  = 1'b1;
            end else begin
                ans_nxt              = in_ep_ctl_pkg::ANS_NAK;
                ep_nxt[ti].underrun  = 1'b1;
            end
        end

        // FIFO load: one more queued packet, count held at two
        if (load_valid_i && (load_ep_i == 2'h1 || load_ep_i == 2'h2)) begin
            if (ep_nxt[load_ep_i[1:1]].pkts != 2'h2) begin
                ep_nxt[load_ep_i[1:1]].pkts = ep_nxt[load_ep_i[1:1]].pkts + in_ep_ctl_pkg::CNT_ONE;
            end
        end

        // Register writes
        if (wr) begin
            if (idx == in_ep_ctl_pkg::IDX_INDEX) begin
                sel_nxt = wb[1:0];
            end else if (idx == in_ep_ctl_pkg::IDX_IRQ_EN) begin
                en_nxt = wb[5:0];
            end else if (idx == in_ep_ctl_pkg::IDX_CTL_HIGH && sel_ok) begin
                ep_nxt[si].iso = wb[in_ep_ctl_pkg::B_ISO];
                ep_nxt[si].dbl = wb[in_ep_ctl_pkg::B_DBL_BUF];
            end else if (idx == in_ep_ctl_pkg::IDX_CTL_LOW && sel_ok) begin
                // Bit 7 is not stored
                if (wb[in_ep_ctl_pkg::B_CLR_TOG]) begin
                    ep_nxt[si].toggle = 1'b0;
                end
                ep_nxt[si].stl_req = wb[in_ep_ctl_pkg::B_SEND_STL];
                // Only a zero write clears, set by a same-cycle stall wins
                if (!wb[in_ep_ctl_pkg::B_STL_SENT]) begin
                    ep_nxt[si].stl_sent = ep_nxt[si].stl_sent & ans_nxt[0] & ans_nxt[1]
                                          & (ti == si) & token_valid_i;
                end
                if (!wb[in_ep_ctl_pkg::B_UNDERRUN]) begin
                    ep_nxt[si].underrun = ep_nxt[si].underrun & (ep_r[si].underrun == 1'b0);
                end
                if (wb[in_ep_ctl_pkg::B_PKT_RDY]) begin
                    // Ready clears at once when a second slot is open
                    ep_nxt[si].rdy = !(ep_r[si].dbl && ep_nxt[si].pkts != 2'h2);
                end
                if (wb[in_ep_ctl_pkg::B_FLUSH] && ep_nxt[si].pkts != in_ep_ctl_pkg::CNT_ZERO) begin
                    ep_nxt[si].flush = 1'b1;
                    ep_nxt[si].pkts  = ep_nxt[si].pkts - in_ep_ctl_pkg::CNT_ONE;
                    ep_nxt[si].rdy   = 1'b0;
                    stat_nxt[3*si + in_ep_ctl_pkg::B_EV_FLUSH] = 1'b1;
                end
            end
        end

        // Register reads
        if (rd) begin
            rdata_nxt = in_ep_ctl_pkg::RD_UNMAPPED;
            if (idx == in_ep_ctl_pkg::IDX_INDEX) begin
                rdata_nxt[1:0] = sel_r;
            end else if (idx == in_ep_ctl_pkg::IDX_IRQ_STAT) begin
                rdata_nxt[5:0] = stat_r;
            end else if (idx == in_ep_ctl_pkg::IDX_IRQ_EN) begin
                rdata_nxt[5:0] = en_r;
            end else if (idx == in_ep_ctl_pkg::IDX_CTL_HIGH && sel_ok) begin
                rdata_nxt[in_ep_ctl_pkg::B_ISO]     = ep_r[si].iso;
                rdata_nxt[in_ep_ctl_pkg::B_DBL_BUF] = ep_r[si].dbl;
            end else if (idx == in_ep_ctl_pkg::IDX_CTL_LOW && sel_ok) begin
                // Clear-toggle and bit 7 read zero
                rdata_nxt[in_ep_ctl_pkg::B_PKT_RDY]  = ep_r[si].rdy;
                rdata_nxt[in_ep_ctl_pkg::B_FIFO_NE]  = ep_r[si].pkts != in_ep_ctl_pkg::CNT_ZERO;
                rdata_nxt[in_ep_ctl_pkg::B_UNDERRUN] = ep_r[si].underrun;
                rdata_nxt[in_ep_ctl_pkg::B_FLUSH]    = ep_r[si].flush;
                rdata_nxt[in_ep_ctl_pkg::B_SEND_STL] = ep_r[si].stl_req;
                rdata_nxt[in_ep_ctl_pkg::B_STL_SENT] = ep_r[si].stl_sent;
            end else if (idx == in_ep_ctl_pkg::IDX_EP_STATUS && sel_ok) begin
                rdata_nxt[1:0] = ep_r[si].pkts;
                rdata_nxt[2]   = ep_r[si].toggle;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < in_ep_ctl_pkg::NUM_EP; i++) begin
                ep_r[i] <= '0;
            end
            sel_r   <= in_ep_ctl_pkg::EP_FIRST;
            stat_r  <= '0;
            en_r    <= '0;
            ack_r   <= 1'b0;
            rdata_r <= '0;
            ans_r   <= in_ep_ctl_pkg::ANS_NONE;
            zl_r    <= 1'b0;
            tog_r   <= 1'b0;
        end else if (clk_en_i) begin
            for (int i = 0; i < in_ep_ctl_pkg::NUM_EP; i++) begin
                ep_r[i] <= ep_nxt[i];
            end
            sel_r   <= sel_nxt;
            stat_r  <= stat_nxt;
            en_r    <= en_nxt;
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
            ans_r   <= ans_nxt;
            zl_r    <= zl_nxt;
            tog_r   <= tog_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_stall_answer: assert property (
        clk_en_i && token_valid_i && token_ep_i == 2'h1 && ep_r[0].stl_req && !ep_r[0].iso
        |=> answer_o == in_ep_ctl_pkg::ANS_STALL)
        else $error("stall request not answered with STALL");
    chk_stall_sent_set: assert property (
        clk_en_i && answer_o == in_ep_ctl_pkg::ANS_NONE && token_valid_i && token_ep_i == 2'h1
        && ep_r[0].stl_req && !ep_r[0].iso |=> ep_r[0].stl_sent)
        else $error("stall-sent flag not set");
    chk_iso_no_stall: assert property (
        clk_en_i && token_valid_i && token_ep_i == 2'h2 && ep_r[1].iso
        |=> answer_o != in_ep_ctl_pkg::ANS_STALL)
        else $error("stall sent in iso mode");
    chk_stall_hold: assert property (
        clk_en_i && ep_r[0].stl_sent && !(wr && idx == in_ep_ctl_pkg::IDX_CTL_LOW)
        |=> ep_r[0].stl_sent)
        else $error("stall-sent cleared by hardware");
    chk_flush_clears: assert property (
        clk_en_i && ep_r[0].flush |=> !ep_r[0].flush)
        else $error("flush bit did not self-clear");
    chk_underrun_zl: assert property (
        answer_zero_len_o |-> answer_o == in_ep_ctl_pkg::ANS_DATA)
        else $error("zero-length packet without data answer");
    chk_toggle_clear: assert property (
        clk_en_i && wr && idx == in_ep_ctl_pkg::IDX_CTL_LOW && sel_r == 2'h1
        && wb[in_ep_ctl_pkg::B_CLR_TOG] && !token_valid_i |=> !ep_r[0].toggle)
        else $error("toggle not cleared");
    chk_ctl_read_zero: assert property (
        clk_en_i && rd && idx == in_ep_ctl_pkg::IDX_CTL_LOW
        |=> avs_readdata_o[in_ep_ctl_pkg::B_CLR_TOG] == 1'b0 && avs_readdata_o[7] == 1'b0)
        else $error("clear-toggle or bit 7 read nonzero");

    cov_stall: cover property (answer_o == in_ep_ctl_pkg::ANS_STALL);
    cov_data: cover property (answer_o == in_ep_ctl_pkg::ANS_DATA && !answer_zero_len_o);
    cov_flush: cover property (ep_r[0].flush);

endmodule

// *** sim/usb_host_model.sv ***
// ------------------------------------------------------------
// Host side: issues IN tokens and reports the answer
// ------------------------------------------------------------
module usb_host_model (
    input  wire logic       clk_i,
    input  wire logic [1:0] answer_i,
    input  wire logic       zero_len_i,
    input  wire logic       toggle_i,
    output logic            token_valid_o,
    output logic [1:0]      token_ep_o,
    output logic            host_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle link at time zero
    initial begin
        token_valid_o = 1'b0;
        token_ep_o    = 2'h0;
        host_ack_o    = 1'b0;
    end

    // One IN token after gap idle cycles; answer taken one cycle later
    task automatic in_token(input logic [1:0] ep, input logic ack, input int gap,
                            output logic [1:0] ans, output logic zl, output logic tog);
        repeat (gap) @(posedge clk_i);
        token_valid_o <= 1'b1;
        token_ep_o    <= ep;
        host_ack_o    <= ack;
        @(posedge clk_i);
        // Released lines show the inverse, never the old value
        token_valid_o <= 1'b0;
        token_ep_o    <= ~ep;
        host_ack_o    <= ~ack;
        @(negedge clk_i);
        ans = answer_i;
        zl  = zero_len_i;
        tog = toggle_i;
        @(posedge clk_i);
    endtask
endmodule

// *** sim/tb_usb_in_endpoint_control_low.sv ***
// Compare two values, count and report
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("BAD t=%0t got %0h exp %0h", $time, got, exp); end end

module tb_usb_in_endpoint_control_low;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and addresses
    // ------------------------------------------------------------
    logic        clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [9:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic        token_valid_i, host_ack_i, answer_zero_len_o, answer_toggle_o;
    logic        load_valid_i, irq_o;
    logic [1:0]  token_ep_i, answer_o, load_ep_i;
    int          fails, samples_checked;
    localparam logic [9:0] A_CTL = {in_ep_ctl_pkg::IDX_CTL_LOW, 2'h0};
    localparam logic [9:0] A_IDX = {in_ep_ctl_pkg::IDX_INDEX, 2'h0};
    localparam logic [9:0] A_HI  = {in_ep_ctl_pkg::IDX_CTL_HIGH, 2'h0};
    localparam logic [9:0] A_ST  = {in_ep_ctl_pkg::IDX_IRQ_STAT, 2'h0};
    localparam logic [9:0] A_CLR = {in_ep_ctl_pkg::IDX_IRQ_CLR, 2'h0};
    localparam logic [9:0] A_EN  = {in_ep_ctl_pkg::IDX_IRQ_EN, 2'h0};
    localparam logic [9:0] A_EPS = {in_ep_ctl_pkg::IDX_EP_STATUS, 2'h0};

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    usb_in_endpoint_control_low i_usb_in_endpoint_control_low (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .token_valid_i(token_valid_i), .token_ep_i(token_ep_i), .host_ack_i(host_ack_i),
        .answer_o(answer_o), .answer_zero_len_o(answer_zero_len_o),
        .answer_toggle_o(answer_toggle_o), .load_valid_i(load_valid_i),
        .load_ep_i(load_ep_i), .irq_o(irq_o));

    usb_host_model i_usb_host_model (
        .clk_i(clk_i), .answer_i(answer_o), .zero_len_i(answer_zero_len_o),
        .toggle_i(answer_toggle_o), .token_valid_o(token_valid_i),
        .token_ep_o(token_ep_i), .host_ack_o(host_ack_i));

    // ------------------------------------------------------------
    // Bus, load and interrupt helpers
    // ------------------------------------------------------------
    // Avalon-MM cycle: hold until waitrequest is seen low at a rising edge
    task automatic bus(input logic we, input logic [9:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        avs_write_i     <= we;
        avs_read_i      <= !we;
        avs_address_i   <= a;
        avs_writedata_i <= {24'h0, d};
        // Waitrequest and read data are taken at the same rising edge
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[7:0];
        avs_write_i     <= 1'b0;
        avs_read_i      <= 1'b0;
        avs_address_i   <= ~a;
        avs_writedata_i <= ~{24'h0, d};
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask
    // One packet loaded into an endpoint FIFO by a one-cycle load strobe
    task automatic load(input logic [1:0] ep);
        load_valid_i <= 1'b1;
        load_ep_i    <= ep;
        @(posedge clk_i);
        load_valid_i <= 1'b0;
        load_ep_i    <= ~ep;
        @(posedge clk_i);
    endtask
    // Interrupt level seen where it has settled
    task automatic chk_irq(input logic e);
        @(negedge clk_i);
        `CHK(irq_o, e)
        @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, unmapped place, default index
    task automatic t_reset;
        logic [7:0] q;
        rd(A_CTL, q); `CHK(q, in_ep_ctl_pkg::CTL_RST)
        wr(10'h3FC, 8'hFF);
        rd(10'h3FC, q); `CHK(q, 8'h00)
        rd(A_IDX, q); `CHK(q, 8'h01)
    endtask
    // Three sends with a toggle clear before the last
    task automatic t_toggle;
        logic [7:0] q;
        logic [1:0] a;
        logic z, t;
        logic exp_t [3] = '{1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 3; i++) begin
            if (i == 2) begin
                wr(A_CTL, 8'h40);
                rd(A_CTL, q); `CHK(q, 8'h00)
            end
            load(2'h1);
            wr(A_CTL, 8'h01);
            rd(A_CTL, q); `CHK(q, 8'h03)
            i_usb_host_model.in_token(2'h1, 1'b1, i, a, z, t);
            `CHK(a, in_ep_ctl_pkg::ANS_DATA)
            `CHK(t, exp_t[i])
            rd(A_CTL, q); `CHK(q, 8'h00)
        end
    endtask
    // Stall held, flag sticky, interrupt masked, enabled, cleared
    task automatic t_stall;
        logic [7:0] q;
        logic [1:0] a;
        logic z, t;
        wr(A_CTL, 8'h10);
        for (int i = 0; i < 2; i++) begin
            i_usb_host_model.in_token(2'h1, 1'b1, 3 * i, a, z, t);
            `CHK(a, in_ep_ctl_pkg::ANS_STALL)
        end
        rd(A_CTL, q); `CHK(q, 8'h30)
        repeat (6) @(posedge clk_i);
        rd(A_CTL, q); `CHK(q, 8'h30)
        rd(A_ST, q); `CHK(q, 8'h05)
        chk_irq(1'b0);
        wr(A_EN, 8'h04);
        chk_irq(1'b1);
        wr(A_CLR, 8'h05);
        rd(A_ST, q); `CHK(q, 8'h00)
        chk_irq(1'b0);
        wr(A_CTL, 8'h00);
        rd(A_CTL, q); `CHK(q, 8'h00)
        i_usb_host_model.in_token(2'h1, 1'b1, 0, a, z, t);
        `CHK(a, in_ep_ctl_pkg::ANS_NAK)
        wr(A_CTL, 8'h00);
    endtask
    // Two packets removed one flush at a time
    task automatic t_flush;
        logic [7:0] q;
        load(2'h1);
        load(2'h1);
        wr(A_CTL, 8'h01);
        rd(A_EPS, q); `CHK(q[1:0], 2'h2)
        wr(A_CTL, 8'h08);
        rd(A_CTL, q); `CHK(q, 8'h02)
        rd(A_EPS, q); `CHK(q[1:0], 2'h1)
        wr(A_CTL, 8'h08);
        rd(A_CTL, q); `CHK(q, 8'h00)
    endtask
    // Second endpoint in iso mode: stall ignored, underrun on empty FIFO
    task automatic t_iso;
        logic [7:0] q;
        logic [1:0] a;
        logic z, t;
        wr(A_IDX, 8'h02);
        wr(A_HI, 8'h40);
        wr(A_CTL, 8'h90);
        rd(A_CTL, q); `CHK(q, 8'h10)
        i_usb_host_model.in_token(2'h2, 1'b0, 0, a, z, t);
        `CHK(a, in_ep_ctl_pkg::ANS_DATA)
        `CHK(z, 1'b1)
        rd(A_CTL, q); `CHK(q, 8'h14)
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #20000;
        fails++;
        wrap_up();
    end
    initial begin
        {clk_i, reset_n_i, avs_read_i, avs_write_i, load_valid_i} = '0;
        {avs_address_i, avs_writedata_i, load_ep_i} = '0;
        {fails, samples_checked} = '0;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_toggle();
        t_stall();
        t_flush();
        t_iso();
        wrap_up();
    end
endmodule
